//--- src/acc_mem_exchange_defines.svh
`ifndef ACC_MEM_EXCHANGE_DEFINES_SVH
`define ACC_MEM_EXCHANGE_DEFINES_SVH

`define OPC_SWAP 6'h2d
`define OPC_SWAP_DEC 6'h2f
`define OPC_SWAP_INC 6'h2e
`define OPC_WD_RESTART 10'h2a0
`define OPC_WD_DISABLE 10'h29c
`define NIBBLE_RESET 4'h0
`define BIT_RESET 1'b0
`define ROW_WRAP_LOW 4'h0
`define ROW_WRAP_HIGH 4'hf

`endif

//--- src/acc_mem_exchange_pkg.sv
package acc_mem_exchange_pkg;
    typedef enum logic [2:0] {
        op_none_type = 3'b000,
        op_swap_type = 3'b001,
        op_swap_dec_type = 3'b010,
        op_swap_inc_type = 3'b011,
        op_wd_restart_type = 3'b100
    } op_kind_type;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] column;
        logic [3:0] row;
    } core_regs_type;

    typedef struct packed {
        logic we;
        logic [3:0] wdata;
    } mem_write_type;
endpackage

//--- src/acc_mem_exchange_exec.sv
// What this block does
// - restart instruction clears the watchdog overflow flag, except when an overflow set arrives in the same cycle.
// - restart skips next instruction when overflow flag was set beforehand.
// - restart directly after disable instruction stops the watchdog.
// - plain swap decoded from upper six bits 101101, low four immediate.
// - decrementing swap decoded from upper six bits 101111.
// - incrementing swap decoded from upper six bits 101110.
// - swaps exchange accumulator with memory word at data pointer.
// - swaps XOR the immediate into the column register.
// - decrementing swap lowers row by one, wrapping modulo sixteen.
// - decrementing swap skips next when new row equals 15.
// - incrementing swap raises row by one, wrapping modulo sixteen.
// - incrementing swap skips next when new row equals 0.
`timescale 1ns/1ns
`include "acc_mem_exchange_defines.svh"

module acc_mem_exchange_exec (
    input wire logic clk,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire logic [9:0] instr,
    input wire logic [3:0] mem_rdata,
    input wire logic watchdog_overflow_set,
    output acc_mem_exchange_pkg::core_regs_type regs,
    output acc_mem_exchange_pkg::mem_write_type mem_wr,
    output logic watchdog_overflow_flag,
    output logic watchdog_stop,
    output logic skip_next
);
    acc_mem_exchange_pkg::op_kind_type kind;
    logic [3:0] imm;
    logic executing;
    logic is_swap;
    logic is_dec;
    logic is_inc;
    logic is_restart;
    logic is_disable;
    logic prev_was_disable;
    logic next_prev_was_disable;
    logic [3:0] next_acc;
    logic [3:0] next_column;
    logic [3:0] next_row;
    logic next_skip;
    logic next_flag;
    logic next_stop;

    // restart is matched on all ten bits since it carries no operand
    function automatic acc_mem_exchange_pkg::op_kind_type decode(input logic [9:0] w);
        logic [5:0] op;
        op = w[9:4];
        if (op == `OPC_SWAP) begin
            decode = acc_mem_exchange_pkg::op_swap_type;
        end else if (op == `OPC_SWAP_DEC) begin
            decode = acc_mem_exchange_pkg::op_swap_dec_type;
        end else if (op == `OPC_SWAP_INC) begin
            decode = acc_mem_exchange_pkg::op_swap_inc_type;
        end else if (w == `OPC_WD_RESTART) begin
            decode = acc_mem_exchange_pkg::op_wd_restart_type;
        end else begin
            decode = acc_mem_exchange_pkg::op_none_type;
        end
    endfunction

    function automatic logic swap_kind(input acc_mem_exchange_pkg::op_kind_type k);
        swap_kind = (k == acc_mem_exchange_pkg::op_swap_type)
            || (k == acc_mem_exchange_pkg::op_swap_dec_type)
            || (k == acc_mem_exchange_pkg::op_swap_inc_type);
    endfunction

    // four-bit arithmetic wraps by itself: 0 - 1 gives 15, 15 + 1 gives 0
    function automatic logic [3:0] row_step(input logic [3:0] r, input logic up);
        if (up) begin
            row_step = r + 4'h1;
        end else begin
            row_step = r - 4'h1;
        end
    endfunction

    function automatic logic row_wrapped(input logic [3:0] r, input logic up);
        if (up) begin
            row_wrapped = (r == `ROW_WRAP_LOW);
        end else begin
            row_wrapped = (r == `ROW_WRAP_HIGH);
        end
    endfunction

    // a skipped word is fetched but discarded
    assign executing = instr_valid && !skip_next;
    assign kind = executing ? decode(instr) : acc_mem_exchange_pkg::op_none_type;
    assign is_swap = swap_kind(kind);
    assign is_dec = (kind == acc_mem_exchange_pkg::op_swap_dec_type);
    assign is_inc = (kind == acc_mem_exchange_pkg::op_swap_inc_type);
    assign is_restart = (kind == acc_mem_exchange_pkg::op_wd_restart_type);
    assign is_disable = executing && (instr == `OPC_WD_DISABLE);
    assign imm = instr[3:0];

    always_comb begin
        next_acc = regs.acc;
        if (is_swap) begin
            next_acc = mem_rdata;
        end
    end

    always_comb begin
        next_column = regs.column;
        if (is_swap) begin
            next_column = regs.column ^ imm;
        end
    end

    always_comb begin
        next_row = regs.row;
        if (is_dec) begin
            next_row = row_step(regs.row, 1'b0);
        end else if (is_inc) begin
            next_row = row_step(regs.row, 1'b1);
        end
    end

    // memory write is combinational so the RAM captures it on the same edge
    always_comb begin
        mem_wr.we = is_swap;
        mem_wr.wdata = regs.acc;
    end

    // row test looks at the stepped value, flag test at the value before clearing
    always_comb begin
        next_skip = skip_next;
        if (instr_valid) begin
            unique case (kind)
                acc_mem_exchange_pkg::op_swap_dec_type: begin
                    next_skip = row_wrapped(next_row, 1'b0);
                end
                acc_mem_exchange_pkg::op_swap_inc_type: begin
                    next_skip = row_wrapped(next_row, 1'b1);
                end
                acc_mem_exchange_pkg::op_wd_restart_type: begin
                    next_skip = watchdog_overflow_flag;
                end
                acc_mem_exchange_pkg::op_swap_type: begin
                    next_skip = 1'b0;
                end
                acc_mem_exchange_pkg::op_none_type: begin
                    next_skip = 1'b0;
                end
                default: begin
                    next_skip = 1'b0;
                end
            endcase
        end
    end

    // hardware set wins over the restart clear
    always_comb begin
        next_flag = watchdog_overflow_flag;
        if (watchdog_overflow_set) begin
            next_flag = 1'b1;
        end else if (is_restart) begin
            next_flag = 1'b0;
        end
    end

    // gaps in valid keep the tracking; any other word in between breaks it
    always_comb begin
        next_prev_was_disable = prev_was_disable;
        if (instr_valid) begin
            next_prev_was_disable = is_disable;
        end
    end

    // sticky until reset; the watchdog cannot be restarted by software
    always_comb begin
        next_stop = watchdog_stop;
        if (is_restart && prev_was_disable) begin
            next_stop = 1'b1;
        end
    end

    // one edge moves all three nibbles, so a swap never shows half done
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regs.acc <= `NIBBLE_RESET;
            regs.column <= `NIBBLE_RESET;
            regs.row <= `NIBBLE_RESET;
        end else begin
            regs.acc <= next_acc;
            regs.column <= next_column;
            regs.row <= next_row;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            skip_next <= `BIT_RESET;
        end else begin
            skip_next <= next_skip;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            watchdog_overflow_flag <= `BIT_RESET;
        end else begin
            watchdog_overflow_flag <= next_flag;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_was_disable <= `BIT_RESET;
        end else begin
            prev_was_disable <= next_prev_was_disable;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            watchdog_stop <= `BIT_RESET;
        end else begin
            watchdog_stop <= next_stop;
        end
    end
endmodule // acc_mem_exchange_exec

//--- bench/acc_mem_exchange_sva.sv
`timescale 1ns/1ns
module acc_mem_exchange_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic instr_valid,
    input wire logic [9:0] instr,
    input wire logic [3:0] mem_rdata,
    input wire logic watchdog_overflow_set,
    input wire acc_mem_exchange_pkg::core_regs_type regs,
    input wire acc_mem_exchange_pkg::mem_write_type mem_wr,
    input wire logic watchdog_overflow_flag,
    input wire logic watchdog_stop,
    input wire logic skip_next
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic ex = instr_valid && !skip_next;
    wire logic sw = ex && instr[9:4] inside {6'h2d, 6'h2e, 6'h2f};
    wire logic wdr = ex && instr == 10'h2a0;
    a_swap_acc: assert property (sw |=> regs.acc == $past(mem_rdata)) else $error("acc");
    a_swap_wr: assert property (sw |-> mem_wr.we && mem_wr.wdata == regs.acc) else $error("wr");
    a_swap_col: assert property (sw |=> regs.column == $past(regs.column ^ instr[3:0]))
        else $error("col");
    a_dec_row: assert property (sw && instr[5:4] == 2'b11 |=> regs.row == $past(regs.row) - 4'h1
        && skip_next == (regs.row == 4'hf)) else $error("dec");
    a_inc_row: assert property (sw && instr[5:4] == 2'b10 |=> regs.row == $past(regs.row) + 4'h1
        && skip_next == (regs.row == 4'h0)) else $error("inc");
    // overflow pulse in the same cycle wins over the clear
    a_wdr_clear: assert property (wdr && !watchdog_overflow_set |=> !watchdog_overflow_flag
        && skip_next == $past(watchdog_overflow_flag)) else $error("wdr");
    a_stop_cause: assert property ($rose(watchdog_stop) |-> $past(wdr)) else $error("stop");
    a_set_wins: assert property (watchdog_overflow_set |=> watchdog_overflow_flag) else $error("set");
    a_skip_void: assert property (instr_valid && skip_next |-> !mem_wr.we
        ##1 $stable(regs) && !skip_next) else $error("skip");
    cover property (sw && instr[5:4] == 2'b11 && regs.row == 4'h0);
    cover property (wdr && watchdog_overflow_flag);
    cover property ($rose(watchdog_stop));
    cover property (wdr && watchdog_overflow_set);
endmodule // acc_mem_exchange_sva
bind acc_mem_exchange_exec acc_mem_exchange_sva chk (
    .clk(clk),
    .rstn(rstn),
    .instr_valid(instr_valid),
    .instr(instr),
    .mem_rdata(mem_rdata),
    .watchdog_overflow_set(watchdog_overflow_set),
    .regs(regs),
    .mem_wr(mem_wr),
    .watchdog_overflow_flag(watchdog_overflow_flag),
    .watchdog_stop(watchdog_stop),
    .skip_next(skip_next)
);

//--- bench/tb_acc_mem_exchange_exec.sv
`timescale 1ns/1ns
module tb_acc_mem_exchange_exec;
    logic clk = 0, rstn = 0, instr_valid = 0, watchdog_overflow_set = 0;
    logic [9:0] instr = 10'h000, rw;
    logic [3:0] mem_rdata = 4'h0, acc = 4'h0, col = 4'h0, row = 4'h0, wd;
    logic flg = 0, skp = 0, stp = 0, dis = 0, we;
    logic [15:0] seed = 16'hda94;
    logic [19:0] q[$], g;
    logic [4:0] wr;
    int miscompares = 0, checks_done = 0;
    acc_mem_exchange_pkg::core_regs_type regs;
    acc_mem_exchange_pkg::mem_write_type mem_wr;
    logic watchdog_overflow_flag, watchdog_stop, skip_next;
    acc_mem_exchange_exec uut (
        .clk(clk),
        .rstn(rstn),
        .instr_valid(instr_valid),
        .instr(instr),
        .mem_rdata(mem_rdata),
        .watchdog_overflow_set(watchdog_overflow_set),
        .regs(regs),
        .mem_wr(mem_wr),
        .watchdog_overflow_flag(watchdog_overflow_flag),
        .watchdog_stop(watchdog_stop),
        .skip_next(skip_next)
    );
    always #2 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic end_sim();
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [9:0] w, input logic [3:0] m);
        @(negedge clk);
        {instr_valid, instr, mem_rdata} = {1'b1, w, m};
        we = !skp && w[9:4] inside {6'h2d, 6'h2e, 6'h2f};
        wd = we ? acc : 4'h0;
        stp |= !skp && w == 10'h2a0 && dis;
        dis = skp ? dis : w == 10'h29c;
        if (skp) skp = 0;
        else if (we) begin
            {acc, col} = {m, col ^ w[3:0]};
            if (w[5]) row = w[4] ? row - 4'h1 : row + 4'h1;
            skp = w[5] && row == {4{w[4]}};
        end else begin
            skp = w == 10'h2a0 && flg;
            flg = flg && w != 10'h2a0;
        end
        q.push_back({acc, col, row, skp, flg, stp, we, wd});
    endtask
    // overflow pulse in the same cycle as the word: the set beats any clear
    task automatic run_ovf(input logic [9:0] w);
        run(w, 4'h0);
        watchdog_overflow_set = 1;
        flg = 1;
        q[q.size() - 1][6] = 1'b1;
        @(negedge clk);
        {instr_valid, watchdog_overflow_set} = 2'b00;
    endtask
    task automatic ovf();
        @(negedge clk);
        {instr_valid, watchdog_overflow_set, flg} = 3'b011;
        @(negedge clk);
        watchdog_overflow_set = 0;
    endtask
    always @(posedge clk) begin
        if (instr_valid) begin
            // mem_wr read before this edge's register updates land
            wr = {mem_wr.we, mem_wr.we ? mem_wr.wdata : 4'h0};
            #1;
            g = {regs, skip_next, watchdog_overflow_flag, watchdog_stop, wr};
            cmp(g, q.pop_front());
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) rstn = 1;
        run(10'h2f3, 4'h9);
        run(10'h2d0, 4'h1);
        run(10'h29c, 4'h0);
        run(10'h2a0, 4'h0);
        ovf();
        run(10'h2a0, 4'h0);
        run(10'h2e5, 4'h3);
        run_ovf(10'h2a0);
        run(10'h2a0, 4'h0);
        for (int i = 0; i < 400; i++) begin
            seed = lfsr(seed);
            if (seed[14:11] == 4'h0) ovf();
            rw = seed[1:0] == 2'b11 ? (seed[6] ? 10'h2a0 : seed[15:6]) : {6'h2d + 6'(seed[1:0]), seed[5:2]};
            run(rw, seed[13:10]);
        end
        @(negedge clk) instr_valid = 0;
        repeat (2) @(posedge clk);
        end_sim();
    end
    initial begin
        #20000;
        miscompares++;
        end_sim();
    end
endmodule // tb_acc_mem_exchange_exec
